// ### logic/mat_acc_defs.svh
// Constants of the accumulator-array add datapath
`ifndef MAT_ACC_DEFS_SVH
`define MAT_ACC_DEFS_SVH

`define SEL_REG_BASE 5'h08
`define LANE_BITS 32
`define ACC_VEC_DIV 8
`define NARROW_TILE_MAX 3'h3
`define BCAST_SECOND_MAX 5'h0F
`define NARROW_PRED_STEP 8'h04
`define WIDE_PRED_STEP 8'h08
`define DEFAULT_VL_BITS 512

`endif

// ### logic/mat_acc_pkg.sv
// Types shared by the accumulator-array add datapath
`default_nettype none

package mat_acc_pkg;

    typedef enum logic [1:0] {
        FORM_MULTI,
        FORM_BCAST,
        FORM_PAIR,
        FORM_TILE
    } form_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SETUP,
        PH_RUN,
        PH_DONE
    } phase_t;

    typedef struct packed {
        form_t form;
        logic quad;
        logic element_size_bit;
        logic [1:0] selector_choice_field;
        logic [2:0] slice_offset_field;
        logic [4:0] first_operand_field;
        logic [4:0] second_operand_field;
        logic [2:0] tile_index_field;
        logic [2:0] row_predicate;
        logic [2:0] column_predicate;
    } cmd_t;

endpackage

`default_nettype wire

// ### logic/matrix_accumulator_add.sv
// Integer add datapath writing into the two-dimensional accumulator array
`include "mat_acc_defs.svh"
`default_nettype none

module matrix_accumulator_add #(
    parameter int VL_BITS = `DEFAULT_VL_BITS
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic cmd_valid_in,
    input wire mat_acc_pkg::cmd_t cmd_in,
    output logic cmd_ready_out,
    input wire logic streaming_enabled_in,
    input wire logic array_enabled_in,
    input wire logic wide_int_capability_flag_in,
    output logic [4:0] selector_reg_num_out,
    input wire logic [31:0] slice_selector_register_in,
    output logic [4:0] src_a_num_out,
    input wire logic [VL_BITS-1:0] src_a_data_in,
    output logic [4:0] src_b_num_out,
    input wire logic [VL_BITS-1:0] src_b_data_in,
    output logic [2:0] row_pred_num_out,
    input wire logic [VL_BITS/8-1:0] row_pred_data_in,
    output logic [2:0] column_pred_num_out,
    input wire logic [VL_BITS/8-1:0] column_pred_data_in,
    output logic [$clog2(VL_BITS/`ACC_VEC_DIV)-1:0] acc_rd_idx_out,
    input wire logic [VL_BITS-1:0] acc_rd_data_in,
    output logic acc_wr_en_out,
    output logic [$clog2(VL_BITS/`ACC_VEC_DIV)-1:0] acc_wr_idx_out,
    output logic [VL_BITS-1:0] acc_wr_data_out,
    output logic exception_out,
    output logic undefined_out,
    output logic done_out
);
    import mat_acc_pkg::*;

    localparam int VECS = VL_BITS / `ACC_VEC_DIV;
    localparam int IW = $clog2(VECS);
    localparam int NL = VL_BITS / `LANE_BITS;
    localparam int PL = VL_BITS / 8;
    localparam int CW = $clog2(NL) + 1;
    localparam logic [IW-1:0] PAIR_MASK = IW'(VECS / 2 - 1);
    localparam logic [IW-1:0] QUAD_MASK = IW'(VECS / 4 - 1);
    localparam logic [IW-1:0] PAIR_STRIDE = IW'(VECS / 2);
    localparam logic [IW-1:0] QUAD_STRIDE = IW'(VECS / 4);
    localparam logic [CW-1:0] NARROW_DIM = CW'(NL);
    localparam logic [CW-1:0] WIDE_DIM = CW'(NL / 2);

    // Power-of-two length keeps the stride modulo a plain mask
    if (VL_BITS < 128 || VL_BITS > 2048 || (VL_BITS & (VL_BITS - 1)) != 0) begin : g_bad_vl
        $error("VL_BITS must be a power of two from 128 to 2048");
    end

    typedef struct packed {
        phase_t phase;
        cmd_t cmd;
        logic [IW-1:0] vec;
        logic [CW-1:0] count;
        logic wr_en;
        logic [IW-1:0] wr_idx;
        logic [VL_BITS-1:0] wr_data;
        logic exc;
        logic undef;
        logic done;
    } state_t;

    state_t st;
    state_t next_st;

    logic is_group;
    logic [IW-1:0] stride;
    logic [IW-1:0] stride_mask;
    logic [IW-1:0] step;
    logic [CW-1:0] members;
    logic [32:0] sel_sum;
    logic [4:0] multi_base_a;
    logic [4:0] multi_base_b;
    logic [7:0] pred_step;
    logic row_active;
    logic [VL_BITS-1:0] operand1;
    logic [VL_BITS-1:0] sum_vec;
    logic [NL-1:0] carry;

    // Fixed lane decode of the latched command
    always_comb begin
        is_group = (st.cmd.form != FORM_TILE);
        stride = st.cmd.quad ? QUAD_STRIDE : PAIR_STRIDE;
        stride_mask = st.cmd.quad ? QUAD_MASK : PAIR_MASK;
        pred_step = st.cmd.element_size_bit ? `WIDE_PRED_STEP : `NARROW_PRED_STEP;
        step = is_group ? stride : IW'(pred_step);
        if (is_group) begin
            members = st.cmd.quad ? CW'(4) : CW'(2);
        end else begin
            members = st.cmd.element_size_bit ? WIDE_DIM : NARROW_DIM;
        end
        sel_sum = {1'b0, slice_selector_register_in} + 33'(st.cmd.slice_offset_field);
        multi_base_a = st.cmd.quad ? {st.cmd.first_operand_field[2:0], 2'b00}
                                   : {st.cmd.first_operand_field[3:0], 1'b0};
        multi_base_b = st.cmd.quad ? {st.cmd.second_operand_field[2:0], 2'b00}
                                   : {st.cmd.second_operand_field[3:0], 1'b0};
    end

    // Register read addresses come straight from state flops
    always_comb begin
        selector_reg_num_out = `SEL_REG_BASE + {3'b000, st.cmd.selector_choice_field};
        acc_rd_idx_out = st.vec;
        row_pred_num_out = st.cmd.row_predicate;
        column_pred_num_out = st.cmd.column_predicate;
        case (st.cmd.form)
            FORM_MULTI: begin
                src_a_num_out = multi_base_a;
                src_b_num_out = multi_base_b + 5'(st.count);
            end
            FORM_BCAST: begin
                src_a_num_out = st.cmd.first_operand_field + 5'(st.count);
                src_b_num_out = st.cmd.second_operand_field & `BCAST_SECOND_MAX;
            end
            FORM_PAIR: begin
                src_a_num_out = multi_base_a + 5'(st.count);
                src_b_num_out = multi_base_b + 5'(st.count);
            end
            default: begin
                src_a_num_out = st.cmd.first_operand_field;
                src_b_num_out = st.cmd.first_operand_field;
            end
        endcase
        operand1 = (st.cmd.form == FORM_MULTI || st.cmd.form == FORM_TILE) ? acc_rd_data_in : src_a_data_in;
        row_active = row_pred_data_in[($clog2(PL))'(st.count) * ($clog2(PL))'(pred_step)];
    end

    // One adder per 32-bit lane; odd lanes chain the carry for 64-bit elements
    for (genvar j = 0; j < NL; j++) begin : g_lane
        logic [31:0] lane_a;
        logic [31:0] lane_b;
        logic [31:0] lane_s;
        logic lane_act;
        logic cin;
        if (j % 2 == 1) begin : g_odd
            assign cin = st.cmd.element_size_bit & carry[j-1];
        end else begin : g_even
            assign cin = 1'b0;
        end
        assign lane_a = operand1[j*`LANE_BITS +: `LANE_BITS];
        // Column bit of the predicate sits at the first byte of each element
        assign lane_act = is_group ? 1'b1 :
            (row_active & column_pred_data_in[st.cmd.element_size_bit ? (j / 2) * 8 : j * 4]);
        assign lane_b = lane_act ? src_b_data_in[j*`LANE_BITS +: `LANE_BITS] : 32'h00000000;
        assign {carry[j], lane_s} = {1'b0, lane_a} + {1'b0, lane_b} + {32'h00000000, cin};
        assign sum_vec[j*`LANE_BITS +: `LANE_BITS] = lane_act ? lane_s : lane_a;
    end

    always_comb begin
        next_st = st;
        next_st.wr_en = 1'b0;
        next_st.exc = 1'b0;
        next_st.undef = 1'b0;
        next_st.done = 1'b0;
        case (st.phase)
            PH_IDLE: begin
                if (cmd_valid_in) begin
                    if (!streaming_enabled_in || !array_enabled_in) begin
                        next_st.exc = 1'b1;
                    end else if (cmd_in.element_size_bit && !wide_int_capability_flag_in) begin
                        next_st.undef = 1'b1;
                    end else if (cmd_in.form == FORM_TILE && !cmd_in.element_size_bit &&
                                 cmd_in.tile_index_field > `NARROW_TILE_MAX) begin
                        next_st.undef = 1'b1;
                    end else begin
                        next_st.cmd = cmd_in;
                        next_st.phase = PH_SETUP;
                    end
                end
            end
            PH_SETUP: begin
                next_st.count = '0;
                if (is_group) begin
                    next_st.vec = sel_sum[IW-1:0] & stride_mask;
                end else begin
                    next_st.vec = IW'(st.cmd.tile_index_field);
                end
                next_st.phase = PH_RUN;
            end
            PH_RUN: begin
                next_st.wr_en = 1'b1;
                next_st.wr_idx = st.vec;
                next_st.wr_data = sum_vec;
                next_st.vec = st.vec + step;
                next_st.count = st.count + CW'(1);
                if (st.count == members - CW'(1)) begin
                    next_st.phase = PH_DONE;
                end
            end
            PH_DONE: begin
                next_st.phase = PH_IDLE;
            end
            default: begin
                next_st.phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        cmd_ready_out = (st.phase == PH_IDLE);
        acc_wr_en_out = st.wr_en;
        acc_wr_idx_out = st.wr_idx;
        acc_wr_data_out = st.wr_data;
        exception_out = st.exc;
        undefined_out = st.undef;
        done_out = (st.phase == PH_DONE);
    end

    // Writes seen since the last accept, for the member count check
    logic [CW:0] wr_seen;
    always_ff @(posedge clk_in) begin
        if (!reset_n_in || st.phase == PH_SETUP) begin
            wr_seen <= '0;
        end else if (acc_wr_en_out) begin
            wr_seen <= wr_seen + (CW+1)'(1);
        end
    end

    exc_on_disable_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (cmd_ready_out && cmd_valid_in && !array_enabled_in) |=> exception_out && cmd_ready_out)
        else $error("disabled array did not raise an exception");

    wide_undef_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (cmd_ready_out && cmd_valid_in && streaming_enabled_in && array_enabled_in &&
         cmd_in.element_size_bit && !wide_int_capability_flag_in) |=> undefined_out ##1 !acc_wr_en_out)
        else $error("wide form ran without the capability");

    tile_range_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (cmd_ready_out && cmd_valid_in && streaming_enabled_in && array_enabled_in &&
         cmd_in.form == FORM_TILE && !cmd_in.element_size_bit && cmd_in.tile_index_field[2])
        |=> undefined_out)
        else $error("narrow tile above three was accepted");

    selector_reg_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (st.phase == PH_SETUP) |-> (selector_reg_num_out >= 5'h08 && selector_reg_num_out <= 5'h0B))
        else $error("selector register outside eight to eleven");

    member_count_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (done_out && st.cmd.form != FORM_TILE) |-> ##1 (wr_seen == (st.cmd.quad ? 4 : 2)))
        else $error("group write count wrong");

    stride_step_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (acc_wr_en_out && $past(acc_wr_en_out) && st.cmd.form != FORM_TILE) |->
        (acc_wr_idx_out == $past(acc_wr_idx_out) + stride))
        else $error("group index did not advance by the stride");

    first_index_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (st.phase == PH_SETUP && st.cmd.form != FORM_TILE) |=>
        (acc_rd_idx_out == (($past(slice_selector_register_in[IW-1:0]) +
         IW'($past(st.cmd.slice_offset_field))) & stride_mask)))
        else $error("first vector index wrong");

    bcast_second_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (st.phase == PH_RUN && st.cmd.form == FORM_BCAST) |-> (src_b_num_out <= 5'h0F))
        else $error("broadcast second operand above fifteen");

    pair_base_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (st.phase == PH_RUN && st.cmd.form == FORM_PAIR && st.count == '0 && st.cmd.quad) |->
        (src_a_num_out == {st.cmd.first_operand_field[2:0], 2'b00}))
        else $error("quad first register not field times four");

    inactive_keep_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (st.phase == PH_RUN && st.cmd.form == FORM_TILE && !row_active) |=>
        (acc_wr_en_out && acc_wr_data_out == $past(acc_rd_data_in)))
        else $error("inactive slice was modified");

    bcast_wrap_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (st.phase == PH_RUN && st.cmd.form == FORM_BCAST && st.count != '0) |->
        (src_a_num_out == $past(src_a_num_out) + 5'h01))
        else $error("broadcast first operand did not step modulo 32");

    done_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        done_out |-> acc_wr_en_out)
        else $error("done without the last write");

endmodule

`default_nettype wire

// ### verification/far_side.sv
// Far-side model: general, vector and predicate registers and the accumulator array
`default_nettype none
module far_side #(
    parameter int VL = 128
) (
    input wire logic clk_in,
    input wire logic [4:0] sel_num_in,
    output logic [31:0] sel_data_out,
    input wire logic [4:0] a_num_in,
    output logic [VL-1:0] a_data_out,
    input wire logic [4:0] b_num_in,
    output logic [VL-1:0] b_data_out,
    input wire logic [2:0] row_num_in,
    output logic [VL/8-1:0] row_data_out,
    input wire logic [2:0] col_num_in,
    output logic [VL/8-1:0] col_data_out,
    input wire logic [$clog2(VL/8)-1:0] rd_idx_in,
    output logic [VL-1:0] rd_data_out,
    input wire logic wr_en_in,
    input wire logic [$clog2(VL/8)-1:0] wr_idx_in,
    input wire logic [VL-1:0] wr_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] gp [0:31];
    logic [VL-1:0] z [0:31];
    logic [VL/8-1:0] p [0:7];
    logic [VL-1:0] acc [0:VL/8-1];
    // ****************************************
    // Register contents
    // ****************************************
    initial begin
        p = '{16'h1111, 16'h0101, 16'h1011, 16'h0111, 16'h1101, 16'h0110, 16'h1001, 16'h1110};
        for (int i = 0; i < 32; i++) begin
            gp[i] = 32'h0001_0000 + 32'(i * 5);
            for (int e = 0; e < VL / 32; e++) begin
                z[i][e*32 +: 32] = 32'(i << 24) | 32'(e);
            end
        end
        // Low lanes near the top so 64-bit sums carry across lanes
        for (int v = 0; v < VL / 8; v++) begin
            for (int e = 0; e < VL / 32; e++) begin
                acc[v][e*32 +: 32] = 32'hFFFF_FF00 | 32'(v * 16 + e);
            end
        end
    end
    assign sel_data_out = gp[sel_num_in];
    assign a_data_out = z[a_num_in];
    assign b_data_out = z[b_num_in];
    assign row_data_out = p[row_num_in];
    assign col_data_out = p[col_num_in];
    assign rd_data_out = acc[rd_idx_in];
    always @(posedge clk_in) begin
        if (wr_en_in) begin
            acc[wr_idx_in] <= wr_data_in;
        end
    end
endmodule
`default_nettype wire

// ### verification/matrix_accumulator_add_tb_top.sv
// Self-checking bench for the accumulator-array add datapath
`default_nettype none
module matrix_accumulator_add_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mat_acc_pkg::*;
    localparam int VL = 128;
    localparam int IW = $clog2(VL / 8);
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic cmd_valid_in = 1'b0;
    cmd_t cmd_in = '0;
    logic stream_en = 1'b1;
    logic array_en = 1'b1;
    logic wide_flag = 1'b1;
    logic cmd_ready_out, acc_wr_en_out, exception_out, undefined_out, done_out, exc_seen, und_seen;
    logic [4:0] sel_num, a_num, b_num;
    logic [2:0] row_num, col_num;
    logic [31:0] sel_data;
    logic [VL-1:0] a_data, b_data, rd_data, wr_data;
    logic [VL/8-1:0] row_data, col_data;
    logic [IW-1:0] rd_idx, wr_idx;
    logic [VL-1:0] ex [0:VL/8-1];
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    int wr_cnt;

    always #4 clk_in = ~clk_in;

    matrix_accumulator_add #(.VL_BITS(VL)) matrix_accumulator_add_inst (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
        .cmd_ready_out(cmd_ready_out), .streaming_enabled_in(stream_en), .array_enabled_in(array_en),
        .wide_int_capability_flag_in(wide_flag), .selector_reg_num_out(sel_num),
        .slice_selector_register_in(sel_data), .src_a_num_out(a_num), .src_a_data_in(a_data),
        .src_b_num_out(b_num), .src_b_data_in(b_data), .row_pred_num_out(row_num),
        .row_pred_data_in(row_data), .column_pred_num_out(col_num), .column_pred_data_in(col_data),
        .acc_rd_idx_out(rd_idx), .acc_rd_data_in(rd_data), .acc_wr_en_out(acc_wr_en_out),
        .acc_wr_idx_out(wr_idx), .acc_wr_data_out(wr_data), .exception_out(exception_out),
        .undefined_out(undefined_out), .done_out(done_out));

    far_side #(.VL(VL)) far_side_inst (
        .clk_in(clk_in), .sel_num_in(sel_num), .sel_data_out(sel_data), .a_num_in(a_num),
        .a_data_out(a_data), .b_num_in(b_num), .b_data_out(b_data), .row_num_in(row_num),
        .row_data_out(row_data), .col_num_in(col_num), .col_data_out(col_data), .rd_idx_in(rd_idx),
        .rd_data_out(rd_data), .wr_en_in(acc_wr_en_out), .wr_idx_in(wr_idx), .wr_data_in(wr_data));

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic check(input logic [VL-1:0] seen, input logic [VL-1:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            test_done();
        end
    end

    function automatic cmd_t mk(input form_t f, input logic q, input logic s, input logic [1:0] ch,
        input logic [2:0] off, input logic [4:0] n, input logic [4:0] m, input logic [2:0] t,
        input logic [2:0] rp, input logic [2:0] cp);
        mk = '{f, q, s, ch, off, n, m, t, rp, cp};
    endfunction

    // Element-wise sum; lanes with en low keep x
    function automatic logic [VL-1:0] vadd(input logic [VL-1:0] x, input logic [VL-1:0] y, input logic w,
        input logic [3:0] en);
        vadd = x;
        for (int e = 0; e < VL / 64; e++) begin
            if (w && en[e]) vadd[e*64 +: 64] = x[e*64 +: 64] + y[e*64 +: 64];
        end
        for (int e = 0; e < VL / 32; e++) begin
            if (!w && en[e]) vadd[e*32 +: 32] = x[e*32 +: 32] + y[e*32 +: 32];
        end
    endfunction

    task automatic exp_apply(input cmd_t c);
        int nreg, stride, vec, step, n, m, t;
        logic [32:0] base;
        logic [3:0] en;
        logic w;
        w = c.element_size_bit;
        nreg = c.quad ? 4 : 2;
        stride = VL / 8 / nreg;
        step = w ? 8 : 4;
        n = int'(c.first_operand_field);
        m = int'(c.second_operand_field);
        t = int'(c.tile_index_field);
        base = 33'(far_side_inst.gp[8 + int'(c.selector_choice_field)]) + 33'(c.slice_offset_field);
        vec = int'(base % 33'(stride));
        if (c.form == FORM_TILE) begin
            for (int r = 0; r < VL / 8 / step; r++) begin
                for (int k = 0; k < 4; k++) begin
                    en[k] = (k * step < VL / 8) && far_side_inst.p[c.row_predicate][r * step] &&
                        far_side_inst.p[c.column_predicate][k * step];
                end
                ex[r * step + t] = vadd(ex[r * step + t], far_side_inst.z[n], w, en);
            end
        end else begin
            for (int r = 0; r < nreg; r++) begin
                case (c.form)
                    FORM_MULTI: ex[vec] = vadd(ex[vec], far_side_inst.z[m * nreg + r], w, 4'hF);
                    FORM_BCAST: ex[vec] = vadd(far_side_inst.z[(n + r) % 32], far_side_inst.z[m % 16], w, 4'hF);
                    default: ex[vec] = vadd(far_side_inst.z[n * nreg + r], far_side_inst.z[m * nreg + r], w, 4'hF);
                endcase
                vec += stride;
            end
        end
    endtask

    // kind 0 runs to completion, otherwise the command must be turned away
    task automatic run_op(input cmd_t c, input int kind);
        logic fin;
        @(posedge clk_in);
        #1;
        ex = far_side_inst.acc;
        if (kind == 0) exp_apply(c);
        wr_cnt = 0;
        exc_seen = 1'b0;
        und_seen = 1'b0;
        fin = 1'b0;
        @(posedge clk_in);
        cmd_in <= c;
        cmd_valid_in <= 1'b1;
        #1;
        check(VL'(cmd_ready_out), VL'(1));
        @(posedge clk_in);
        cmd_valid_in <= 1'b0;
        // Refusal pulses stand only in the cycle right after the accept
        #1;
        exc_seen |= exception_out;
        und_seen |= undefined_out;
        for (int i = 0; i < 20 && !fin; i++) begin
            @(posedge clk_in);
            #1;
            wr_cnt += int'(acc_wr_en_out);
            exc_seen |= exception_out;
            und_seen |= undefined_out;
            fin = done_out | (kind != 0 && i == 8);
        end
        if (kind == 0) check(VL'(acc_wr_en_out), VL'(1));
        @(posedge clk_in);
        #1;
    endtask

    task automatic check_acc();
        for (int v = 0; v < VL / 8; v++) begin
            check(far_side_inst.acc[v], ex[v]);
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sc_multi_pair();
        run_op(mk(FORM_MULTI, 1'b0, 1'b0, 2'h2, 3'h7, 5'h00, 5'h0B, 3'h0, 3'h0, 3'h0), 0);
        check(VL'(wr_cnt), VL'(2));
        check_acc();
    endtask

    task automatic sc_multi_quad_wide();
        run_op(mk(FORM_MULTI, 1'b1, 1'b1, 2'h3, 3'h0, 5'h00, 5'h05, 3'h0, 3'h0, 3'h0), 0);
        check(VL'(wr_cnt), VL'(4));
        check_acc();
    endtask

    task automatic sc_bcast_wrap();
        run_op(mk(FORM_BCAST, 1'b1, 1'b0, 2'h0, 3'h3, 5'h1E, 5'h0F, 3'h0, 3'h0, 3'h0), 0);
        check(VL'(wr_cnt), VL'(4));
        check_acc();
    endtask

    task automatic sc_pair_quad();
        run_op(mk(FORM_PAIR, 1'b1, 1'b0, 2'h1, 3'h5, 5'h02, 5'h06, 3'h0, 3'h0, 3'h0), 0);
        check(VL'(wr_cnt), VL'(4));
        check_acc();
    endtask

    task automatic sc_tiles();
        run_op(mk(FORM_TILE, 1'b0, 1'b0, 2'h0, 3'h0, 5'h09, 5'h00, 3'h3, 3'h6, 3'h3), 0);
        check(VL'(wr_cnt), VL'(4));
        check_acc();
        run_op(mk(FORM_TILE, 1'b0, 1'b1, 2'h0, 3'h0, 5'h11, 5'h00, 3'h7, 3'h4, 3'h2), 0);
        check(VL'(wr_cnt), VL'(2));
        check_acc();
    endtask

    task automatic sc_refused();
        @(posedge clk_in);
        stream_en <= 1'b0;
        run_op(mk(FORM_MULTI, 1'b0, 1'b0, 2'h0, 3'h1, 5'h00, 5'h02, 3'h0, 3'h0, 3'h0), 1);
        check(VL'({exc_seen, wr_cnt[0]}), VL'(2));
        @(posedge clk_in);
        stream_en <= 1'b1;
        array_en <= 1'b0;
        run_op(mk(FORM_TILE, 1'b0, 1'b0, 2'h0, 3'h0, 5'h01, 5'h00, 3'h1, 3'h0, 3'h0), 1);
        check(VL'({exc_seen, wr_cnt[0]}), VL'(2));
        @(posedge clk_in);
        array_en <= 1'b1;
        wide_flag <= 1'b0;
        run_op(mk(FORM_MULTI, 1'b0, 1'b1, 2'h0, 3'h1, 5'h00, 5'h02, 3'h0, 3'h0, 3'h0), 2);
        check(VL'({exc_seen, und_seen}), VL'(1));
        @(posedge clk_in);
        wide_flag <= 1'b1;
        run_op(mk(FORM_TILE, 1'b0, 1'b0, 2'h0, 3'h0, 5'h01, 5'h00, 3'h5, 3'h0, 3'h0), 2);
        check(VL'({exc_seen, und_seen}), VL'(1));
        check_acc();
    endtask

    initial begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        sc_multi_pair();
        sc_multi_quad_wide();
        sc_bcast_wrap();
        sc_pair_quad();
        sc_tiles();
        sc_refused();
        test_done();
    end
endmodule
`default_nettype wire
